/* shared/sync_burst_sram_pkg.sv */
`default_nettype none
package sync_burst_sram_pkg;
	// Array geometry: 1M words of four data bytes plus four parity bits
	localparam int ADDR_W = 20;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int DQ_W = LANES * LANE_W;
	localparam int WORD_W = DQ_W + LANES;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int BURST_W = 2;
	localparam int HI_W = ADDR_W - BURST_W;

	// Reset values, burst step and lane masks
	localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic MODE_STRAP_RST = 1'b1;
	localparam logic SYNC_RST = 1'b0;
	localparam logic OE_SYNC_RST = 1'b1;
	localparam logic [LANES-1:0] ALL_LANES = 4'hF;
	localparam logic [LANES-1:0] NO_LANES = 4'h0;

	// Port activity states
	typedef enum logic [1:0] {
		ST_DESELECTED,
		ST_ACTIVE,
		ST_SLEEPING
	} port_state_e;
endpackage : sync_burst_sram_pkg
`default_nettype wire

/* verilog/sync_burst_sram_port.sv */
`default_nettype none
module sync_burst_sram_port (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic [sync_burst_sram_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_processor_addr_strobe_n,
	input wire logic i_controller_addr_strobe_n,
	input wire logic i_burst_step_n,
	input wire logic i_chip_select_a_n,
	input wire logic i_chip_select_b,
	input wire logic i_chip_select_c_n,
	input wire logic i_lane_write_qualifier_n,
	input wire logic [sync_burst_sram_pkg::LANES-1:0] i_byte_lane_selects_n,
	input wire logic i_all_bytes_write_n,
	input wire logic i_output_enable_n,
	input wire logic i_sleep_request,
	input wire logic i_burst_order_mode,
	input wire logic [sync_burst_sram_pkg::DQ_W-1:0] i_dq,
	input wire logic [sync_burst_sram_pkg::LANES-1:0] i_parity_lines,
	output logic [sync_burst_sram_pkg::DQ_W-1:0] o_dq,
	output logic [sync_burst_sram_pkg::LANES-1:0] o_parity_lines,
	output logic o_data_oe,
	output logic o_sleep_active
);

	typedef struct packed {
		sync_burst_sram_pkg::port_state_e state;
		logic [sync_burst_sram_pkg::HI_W-1:0] addr_hi;
		logic [sync_burst_sram_pkg::BURST_W-1:0] burst_base;
		logic [sync_burst_sram_pkg::BURST_W-1:0] burst_cnt;
		logic write_seen;
		logic emerge_mask;
		logic [sync_burst_sram_pkg::WORD_W-1:0] rd_word;
		logic oe_sync1;
		logic oe_sync2;
		logic sleep_sync1;
		logic sleep_sync2;
		logic mode_sync1;
		logic mode_sync2;
	} port_s;

	port_s state_q;
	port_s state_d;
	logic rst_sync1_q;
	logic rstn_q;
	logic [sync_burst_sram_pkg::WORD_W-1:0] mem [0:sync_burst_sram_pkg::DEPTH-1];
	logic sel_in;
	logic load_p;
	logic load_c;
	logic load;
	logic wr_req;
	logic [sync_burst_sram_pkg::LANES-1:0] wr_lanes;
	logic mem_we;
	logic [sync_burst_sram_pkg::ADDR_W-1:0] wr_addr;
	logic [sync_burst_sram_pkg::ADDR_W-1:0] cur_addr;
	logic [sync_burst_sram_pkg::ADDR_W-1:0] rd_addr;
	logic [sync_burst_sram_pkg::WORD_W-1:0] wr_word;
	logic [sync_burst_sram_pkg::BURST_W-1:0] next_cnt;

	// Burst offset for a start value and step count; add or XOR by strap
	function automatic logic [sync_burst_sram_pkg::BURST_W-1:0] burst_offset(
		input logic [sync_burst_sram_pkg::BURST_W-1:0] base,
		input logic [sync_burst_sram_pkg::BURST_W-1:0] cnt,
		input logic interleaved
	);
		burst_offset = interleaved ? (base ^ cnt) : 2'(base + cnt);
	endfunction : burst_offset

	//////////////////////////////////////////////////////////////////////////////
	// Reset release through two flops; assertion is still immediate
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync1_q <= sync_burst_sram_pkg::SYNC_RST;
			rstn_q <= sync_burst_sram_pkg::SYNC_RST;
		end else begin
			rst_sync1_q <= 1'b1;
			rstn_q <= rst_sync1_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Strobe decode; sleep shuts both strobes out
	always_comb begin
		sel_in = !i_chip_select_a_n && i_chip_select_b && !i_chip_select_c_n;
		load_p = (state_q.state != sync_burst_sram_pkg::ST_SLEEPING)
			&& !i_processor_addr_strobe_n && !i_chip_select_a_n;
		load_c = (state_q.state != sync_burst_sram_pkg::ST_SLEEPING)
			&& !i_controller_addr_strobe_n && !load_p;
		load = load_p || load_c;
	end

	// Write qualification: global write overrides lane selects and qualifier
	always_comb begin
		if (!i_all_bytes_write_n) begin
			wr_lanes = sync_burst_sram_pkg::ALL_LANES;
		end else if (!i_lane_write_qualifier_n) begin
			wr_lanes = ~i_byte_lane_selects_n;
		end else begin
			wr_lanes = sync_burst_sram_pkg::NO_LANES;
		end
		wr_req = wr_lanes != sync_burst_sram_pkg::NO_LANES;
	end

	// Address path; processor-strobe edge never writes, its data comes next edge
	always_comb begin
		cur_addr = {state_q.addr_hi,
			burst_offset(state_q.burst_base, state_q.burst_cnt, state_q.mode_sync2)};
		next_cnt = state_q.burst_cnt;
		if (!load && state_q.state == sync_burst_sram_pkg::ST_ACTIVE && !i_burst_step_n) begin
			next_cnt = 2'(state_q.burst_cnt + sync_burst_sram_pkg::BURST_STEP);
		end
		mem_we = wr_req && ((load_c && sel_in)
			|| (!load && state_q.state == sync_burst_sram_pkg::ST_ACTIVE));
		wr_addr = load_c ? i_addr : cur_addr;
		wr_word = {i_parity_lines, i_dq};
		if (load) begin
			rd_addr = i_addr;
		end else begin
			rd_addr = {state_q.addr_hi,
				burst_offset(state_q.burst_base, next_cnt, state_q.mode_sync2)};
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Next state of the port
	always_comb begin
		state_d = state_q;
		state_d.oe_sync1 = i_output_enable_n;
		state_d.oe_sync2 = state_q.oe_sync1;
		state_d.sleep_sync1 = i_sleep_request;
		state_d.sleep_sync2 = state_q.sleep_sync1;
		state_d.mode_sync1 = i_burst_order_mode;
		state_d.mode_sync2 = state_q.mode_sync1;
		state_d.burst_cnt = next_cnt;
		state_d.write_seen = mem_we;
		state_d.emerge_mask = load && sel_in
			&& state_q.state != sync_burst_sram_pkg::ST_ACTIVE;
		if (load) begin
			state_d.addr_hi = i_addr[sync_burst_sram_pkg::ADDR_W-1:sync_burst_sram_pkg::BURST_W];
			state_d.burst_base = i_addr[sync_burst_sram_pkg::BURST_W-1:0];
			state_d.burst_cnt = sync_burst_sram_pkg::BURST_CNT_RST;
		end
		// Flow-through: the word for the address taken at this edge is ready after it
		state_d.rd_word = mem[rd_addr];
		unique case (state_q.state)
			sync_burst_sram_pkg::ST_SLEEPING: begin
				if (!state_q.sleep_sync2) begin
					state_d.state = sync_burst_sram_pkg::ST_DESELECTED;
				end
			end
			sync_burst_sram_pkg::ST_DESELECTED, sync_burst_sram_pkg::ST_ACTIVE: begin
				if (state_q.sleep_sync2) begin
					state_d.state = sync_burst_sram_pkg::ST_SLEEPING;
				end else if (load) begin
					state_d.state = sel_in ? sync_burst_sram_pkg::ST_ACTIVE
						: sync_burst_sram_pkg::ST_DESELECTED;
				end
			end
			default: begin
				state_d.state = sync_burst_sram_pkg::ST_DESELECTED;
			end
		endcase
	end

	// State register; strap sync resets high so an open strap means interleaved
	always_ff @(posedge i_sys_clk or negedge rstn_q) begin
		if (!rstn_q) begin
			state_q <= '{state: sync_burst_sram_pkg::ST_DESELECTED,
				addr_hi: '0,
				burst_base: sync_burst_sram_pkg::BURST_CNT_RST,
				burst_cnt: sync_burst_sram_pkg::BURST_CNT_RST,
				write_seen: 1'b0,
				emerge_mask: 1'b0,
				rd_word: '0,
				oe_sync1: sync_burst_sram_pkg::OE_SYNC_RST,
				oe_sync2: sync_burst_sram_pkg::OE_SYNC_RST,
				sleep_sync1: sync_burst_sram_pkg::SYNC_RST,
				sleep_sync2: sync_burst_sram_pkg::SYNC_RST,
				mode_sync1: sync_burst_sram_pkg::MODE_STRAP_RST,
				mode_sync2: sync_burst_sram_pkg::MODE_STRAP_RST};
		end else begin
			state_q <= state_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Array write per lane; one process owns the array so it has a single driver
	always_ff @(posedge i_sys_clk) begin
		for (int g = 0; g < sync_burst_sram_pkg::LANES; g++) begin
			if (mem_we && wr_lanes[g]) begin
				mem[wr_addr][g*sync_burst_sram_pkg::LANE_W +: sync_burst_sram_pkg::LANE_W]
					<= wr_word[g*sync_burst_sram_pkg::LANE_W +: sync_burst_sram_pkg::LANE_W];
				mem[wr_addr][sync_burst_sram_pkg::DQ_W + g] <= wr_word[sync_burst_sram_pkg::DQ_W + g];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Outputs; enable also drops at once when write inputs show, to avoid contention
	assign o_dq = state_q.rd_word[sync_burst_sram_pkg::DQ_W-1:0];
	assign o_parity_lines = state_q.rd_word[sync_burst_sram_pkg::WORD_W-1:sync_burst_sram_pkg::DQ_W];
	assign o_data_oe = !state_q.oe_sync2
		&& state_q.state == sync_burst_sram_pkg::ST_ACTIVE
		&& !state_q.write_seen && !state_q.emerge_mask && !wr_req;
	assign o_sleep_active = state_q.state == sync_burst_sram_pkg::ST_SLEEPING;

	//////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!rstn_q);

	pstrobe_load_a: assert property (load_p |=> state_q.addr_hi == $past(i_addr[19:2])
		&& state_q.burst_base == $past(i_addr[1:0]) && state_q.burst_cnt == 2'h0)
		else $error("processor strobe did not load address");
	cstrobe_load_a: assert property (!i_controller_addr_strobe_n && i_processor_addr_strobe_n
		&& !o_sleep_active |=> state_q.burst_base == $past(i_addr[1:0]))
		else $error("controller strobe did not load counter");
	strobe_priority_a: assert property (!i_processor_addr_strobe_n && !i_chip_select_a_n
		|-> !mem_we)
		else $error("controller strobe acted beside processor strobe");
	ce1_gate_a: assert property (i_chip_select_a_n && i_controller_addr_strobe_n
		|=> $stable(state_q.addr_hi) && $stable(state_q.burst_base))
		else $error("processor strobe taken while first select high");
	lane_qualify_a: assert property (mem_we && i_all_bytes_write_n |-> !i_lane_write_qualifier_n)
		else $error("byte write without qualifier");
	sleep_float_a: assert property (state_q.sleep_sync2 |=> o_sleep_active && !o_data_oe)
		else $error("sleep not entered or lines driven");
	oe_float_a: assert property (state_q.oe_sync2 |-> !o_data_oe)
		else $error("lines driven with output enable high");
	write_float_a: assert property (mem_we |=> !o_data_oe)
		else $error("lines driven in write data phase");
	global_write_a: assert property (!i_all_bytes_write_n |-> wr_lanes == 4'hF)
		else $error("global write missed a lane");
	linear_step_a: assert property (!load && state_q.state == sync_burst_sram_pkg::ST_ACTIVE
		&& !i_burst_step_n && !state_q.mode_sync2 && !state_q.sleep_sync2
		|=> cur_addr[1:0] == 2'($past(cur_addr[1:0]) + 2'h1))
		else $error("linear burst step wrong");
	interleave_step_a: assert property (!load && state_q.state == sync_burst_sram_pkg::ST_ACTIVE
		&& !i_burst_step_n && state_q.mode_sync2 && $stable(state_q.mode_sync2)
		|=> cur_addr[1:0] == (state_q.burst_base ^ 2'($past(state_q.burst_cnt) + 2'h1)))
		else $error("interleaved burst step wrong");
	select_gate_a: assert property (load && !sel_in && !state_q.sleep_sync2
		|=> state_q.state == sync_burst_sram_pkg::ST_DESELECTED ##1 !o_data_oe)
		else $error("deselected port still active");

	read_burst_c: cover property (load_p && sel_in ##1 !i_burst_step_n[*3]);
	ctrl_write_c: cover property (load_c && sel_in && wr_req);
	sleep_cycle_c: cover property (o_sleep_active ##[1:20] !o_sleep_active);
	drive_c: cover property (o_data_oe [*2]);

endmodule : sync_burst_sram_port
`default_nettype wire

/* verif/host_bus_model.sv */
`default_nettype none
module host_bus_model (
	input wire logic i_sys_clk,
	input wire logic i_drive,
	input wire logic [35:0] i_wdata,
	input wire logic i_dev_oe,
	input wire logic [35:0] i_dev_word,
	output logic [35:0] o_line,
	output logic o_clash
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0] last_q = 36'h0_0000_0000;

	// Released lines show the inverse of the last value, so stale data never looks good
	always_comb begin
		if (i_dev_oe) begin
			o_line = i_dev_word;
		end else if (i_drive) begin
			o_line = i_wdata;
		end else begin
			o_line = ~last_q;
		end
	end

	// Track the last settled wire level
	always @(posedge i_sys_clk) begin
		last_q <= o_line;
	end

	// Both parties driving at once is a fault on the shared lines
	assign o_clash = i_dev_oe & i_drive;
endmodule : host_bus_model
`default_nettype wire

/* verif/testbench.sv */
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn, ps_n, cs_n, step_n, ca_n, cb, cc_n, bwe_n, gw_n, oe_n, slp, mode, drv;
	logic oe, clash, sa;
	logic [19:0] addr, blk;
	logic [3:0] bsel_n;
	logic [1:0] lo;
	logic [31:0] rv;
	logic [35:0] wdata, line, dword;
	logic [35:0] mem [int];
	int err_count = 0;
	int samples_checked = 0;
	int seed = 29;

	sync_burst_sram_port DUT (.i_sys_clk(clk), .i_resetn(rstn), .i_addr(addr),
		.i_processor_addr_strobe_n(ps_n), .i_controller_addr_strobe_n(cs_n),
		.i_burst_step_n(step_n), .i_chip_select_a_n(ca_n), .i_chip_select_b(cb),
		.i_chip_select_c_n(cc_n), .i_lane_write_qualifier_n(bwe_n),
		.i_byte_lane_selects_n(bsel_n), .i_all_bytes_write_n(gw_n), .i_output_enable_n(oe_n),
		.i_sleep_request(slp), .i_burst_order_mode(mode), .i_dq(line[31:0]),
		.i_parity_lines(line[35:32]), .o_dq(dword[31:0]), .o_parity_lines(dword[35:32]),
		.o_data_oe(oe), .o_sleep_active(sa));
	host_bus_model bus (.i_sys_clk(clk), .i_drive(drv), .i_wdata(wdata), .i_dev_oe(oe),
		.i_dev_word(dword), .o_line(line), .o_clash(clash));

	// Free-running system clock
	always #12.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [35:0] r36();
		logic [63:0] t;
		t = {$random(seed), $random(seed)};
		return t[35:0];
	endfunction : r36

	// Expected low address bits of burst beat k
	function automatic logic [1:0] bseq(input logic [1:0] b, input logic [1:0] k);
		return mode ? (b ^ k) : (b + k);
	endfunction : bseq

	task automatic idle();
		ps_n = 1'b1;
		cs_n = 1'b1;
		step_n = 1'b1;
		gw_n = 1'b1;
		bwe_n = 1'b1;
		bsel_n = 4'hF;
		drv = 1'b0;
		ca_n = 1'b0;
		cb = 1'b1;
		cc_n = 1'b0;
	endtask : idle

	// Controller-strobe write; the model keeps only the lanes that really store
	task automatic wr(input logic [19:0] a, input logic [35:0] d, input logic g,
		input logic b, input logic [3:0] s);
		logic [3:0] ln;
		logic [35:0] t;
		ln = !g ? 4'hF : (!b ? ~s : 4'h0);
		t = mem.exists(a) ? mem[a] : 36'h0_0000_0000;
		cs_n = 1'b0;
		addr = a;
		gw_n = g;
		bwe_n = b;
		bsel_n = s;
		wdata = d;
		drv = |ln;
		#1 `CHK(clash, 1'b0)
		@(negedge clk);
		idle();
		if (|ln) `CHK(oe, 1'b0)
		@(negedge clk);
		for (int k = 0; k < 4; k++) begin
			if (ln[k]) begin
				t[8*k +: 8] = d[8*k +: 8];
				t[32+k] = d[32+k];
			end
		end
		mem[a] = t;
	endtask : wr

	// Deselect, then processor-strobe read with n beats
	task automatic rd(input logic [19:0] a, input int n);
		cs_n = 1'b0;
		cb = 1'b0;
		@(negedge clk);
		`CHK(oe, 1'b0)
		cs_n = 1'b1;
		cb = 1'b1;
		ps_n = 1'b0;
		addr = a;
		@(negedge clk);
		ps_n = 1'b1;
		`CHK(dword, mem[a])
		`CHK(oe, 1'b0)
		for (int k = 1; k < n; k++) begin
			step_n = 1'b0;
			@(negedge clk);
			`CHK(oe, ~oe_n)
			`CHK(dword, mem[{a[19:2], bseq(a[1:0], k[1:0])}])
		end
		step_n = 1'b1;
	endtask : rd

	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; inputs move on falling edges only
	initial begin
		idle();
		addr = 20'h0_0000;
		wdata = 36'h0_0000_0000;
		oe_n = 1'b0;
		slp = 1'b0;
		rstn = 1'b0;
		mode = 1'b1;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		for (int m = 1; m >= 0; m--) begin
			mode = m[0];
			repeat (4) @(negedge clk);
			rv = $random(seed);
			blk = rv[19:0];
			lo = rv[21:20];
			for (int i = 0; i < 4; i++) wr({blk[19:2], i[1:0]}, r36(), 1'b0, 1'b1, 4'hF);
			rv = $random(seed);
			wr({blk[19:2], 2'h1}, r36(), 1'b1, 1'b0, rv[3:0]);
			wr({blk[19:2], 2'h2}, r36(), 1'b1, 1'b1, 4'h0);
			rd({blk[19:2], lo}, 4);
		end
		// Processor strobe with the first select high must not reload
		ps_n = 1'b0;
		ca_n = 1'b1;
		addr = {blk[19:2], lo};
		@(negedge clk);
		ca_n = 1'b0;
		`CHK(dword, mem[{blk[19:2], bseq(lo, 2'h3)}])
		// Both strobes with write inputs: processor load wins and nothing is written
		cs_n = 1'b0;
		gw_n = 1'b0;
		addr = {blk[19:2], bseq(lo, 2'h1)};
		@(negedge clk);
		idle();
		`CHK(dword, mem[addr])
		// Sleep: controller strobe refused, lines float, contents kept
		slp = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(sa, 1'b1)
		cs_n = 1'b0;
		gw_n = 1'b0;
		addr = {blk[19:2], lo};
		@(negedge clk);
		idle();
		`CHK(oe, 1'b0)
		slp = 1'b0;
		repeat (5) @(negedge clk);
		`CHK(sa, 1'b0)
		rd({blk[19:2], lo}, 4);
		oe_n = 1'b1;
		repeat (3) @(negedge clk);
		rd({blk[19:2], lo}, 2);
		report_and_stop();
	end

	// Watchdog sized well beyond the 73 or so cycles the sequence needs
	initial begin
		#(5000 * 25);
		err_count++;
		report_and_stop();
	end
endmodule : testbench
`undef CHK
`default_nettype wire
